// ==== design/utx_pkg.sv ====
// Constants, register map and state types for the serial character engine.
// Assumes one 200 MHz clock and a plain strobe register port.
package utx_pkg;
    localparam logic [7:0] A_CR1  = 8'h00;
    localparam logic [7:0] A_CR2  = 8'h04;
    localparam logic [7:0] A_BRR  = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_THR  = 8'h10;
    localparam logic [7:0] A_RXD  = 8'h14;
    localparam logic [7:0] A_REQ  = 8'h18;
    // control_reg_one
    localparam int B_UNIT_ON = 0;
    localparam int B_RXEN    = 2;
    localparam int B_TXEN    = 3;
    localparam int B_RXIE    = 5;
    localparam int B_DONEIE  = 6;
    localparam int B_EMPTYIE = 7;
    localparam int B_WLEN    = 10;
    localparam int B_OVER8   = 15;
    localparam logic [31:0] CR1_MASK = 32'h0000_8CED;
    localparam logic [31:0] CR1_RST  = 32'h0000_0000;
    // control_reg_two
    localparam int B_CLKEN  = 11;
    localparam int B_STOP   = 12;
    localparam int B_RXINV  = 16;
    localparam int B_TXINV  = 17;
    localparam logic [31:0] CR2_MASK = 32'h0003_3800;
    localparam logic [31:0] CR2_RST  = 32'h0000_0000;
    localparam logic [15:0] BRR_RST  = 16'h0010;
    // Status and request bits
    localparam int B_NOISE = 2;
    localparam int B_RXRDY = 5;
    localparam int B_DONE  = 6;
    localparam int B_EMPTY = 7;
    localparam int B_BRK   = 8;
    localparam int B_BRKRQ = 1;
    // Stop field, word length and oversampling codes
    localparam logic [1:0] STOP_1  = 2'b00;
    localparam logic [1:0] STOP_H  = 2'b01;
    localparam logic [1:0] STOP_2  = 2'b10;
    localparam logic [1:0] STOP_1H = 2'b11;
    localparam logic [1:0] WL_7 = 2'b10;
    localparam logic [1:0] WL_9 = 2'b01;
    localparam logic [4:0] OSR16 = 5'h10;
    localparam logic [4:0] OSR8  = 5'h08;
    localparam logic [3:0] SAMP_LAST = 4'hA;
    typedef enum logic [1:0] {TX_OFF, TX_SHIFT, TX_STOP, TX_IDLE} utx_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} utx_rx_st_t;
endpackage : utx_pkg

// ==== design/utx_core.sv ====
// Serial character engine: transmitter, break/idle frames, start detect.
// Registers reached over a plain strobe port; read data one cycle later.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module utx_core
    import utx_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    input  wire logic        rx_i,
    output logic             tx_o,
    output logic             sync_serial_clk_out_o,
    output logic             irq_o
);
    logic [31:0]      cr1_q;
    logic [31:0]      cr2_q;
    logic [DIV_W-1:0] brr_q;
    logic [DIV_W-1:0] pre_q;
    logic [8:0]       thr_q;
    logic             tx_buffer_empty_q;
    logic             tx_done_q;
    logic             break_pending_q;
    logic             rx_data_ready_q;
    logic             noise_flag_q;
    logic [8:0]       rxbuf_q;
    utx_tx_st_t       tx_st_q;
    logic [10:0]      tx_sh_q;
    logic [3:0]       tx_bits_q;
    logic [5:0]       tx_cnt_q;
    logic             tx_dat_q;
    logic             tx_brk_q;
    utx_rx_st_t       rx_st_q;
    logic [2:0]       rx_hist_q;
    logic [3:0]       rx_n_q;
    logic [1:0]       rx_z1_q;
    logic [1:0]       rx_z2_q;
    logic             rx_nz_q;
    logic [4:0]       rx_cnt_q;
    logic [3:0]       rx_k_q;
    logic [8:0]       rx_sh_q;

    logic             ce;
    logic             wr_cr1;
    logic             wr_cr2;
    logic             wr_thr;
    logic             wr_req;
    logic             rd_rxd;
    logic             tx_enable;
    logic             rx_enable;
    logic [3:0]       dbits;
    logic [4:0]       osr;
    logic [5:0]       stop_ticks;
    logic [DIV_W-1:0] pre_nxt;
    logic             os_tick;
    logic             t_tick;
    logic             bit_end;
    logic             stop_end;
    logic             frame_end;
    logic             load_data;
    logic             brk_clr;
    logic             r_tick;
    logic             rxs;
    logic [3:0]       idx;
    logic [1:0]       z1n;
    logic [1:0]       z2n;
    logic             rx_xfer;

    assign ce     = clk_en_i;
    assign wr_cr1 = ce && wr_i && addr_i == A_CR1;
    assign wr_cr2 = ce && wr_i && addr_i == A_CR2;
    assign wr_thr = ce && wr_i && addr_i == A_THR;
    assign wr_req = ce && wr_i && addr_i == A_REQ;
    assign rd_rxd = ce && rd_i && addr_i == A_RXD;

    assign tx_enable = cr1_q[B_UNIT_ON] && cr1_q[B_TXEN];
    assign rx_enable = cr1_q[B_UNIT_ON] && cr1_q[B_RXEN];

    always_comb begin
        unique case (cr1_q[B_WLEN +: 2])
            WL_7:    dbits = 4'd7;
            WL_9:    dbits = 4'd9;
            default: dbits = 4'd8;
        endcase
    end

    assign osr = cr1_q[B_OVER8] ? OSR8 : OSR16;

    // Stop length in oversample ticks; a break always ends with two bits
    always_comb begin
        logic [2:0] halves;
        halves = 3'd2;
        if (tx_brk_q) begin
            halves = 3'd4;
        end else begin
            unique case (cr2_q[B_STOP +: 2])
                STOP_1:  halves = 3'd2;
                STOP_H:  halves = 3'd1;
                STOP_2:  halves = 3'd4;
                STOP_1H: halves = 3'd3;
            endcase
        end
        stop_ticks = cr1_q[B_OVER8] ? {1'b0, halves, 2'b00} : {halves, 3'b000};
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cr1_q <= CR1_RST;
            cr2_q <= CR2_RST;
            brr_q <= DIV_W'(BRR_RST);
        end else begin
            if (wr_cr1) begin
                cr1_q <= wr_data_i & CR1_MASK;
            end
            if (wr_cr2) begin
                cr2_q <= wr_data_i & CR2_MASK;
            end
            if (ce && wr_i && addr_i == A_BRR) begin
                brr_q <= wr_data_i[DIV_W-1:0];
            end
        end
    end

    // Shared baud prescaler; divisor 0 or 1 ticks every cycle
    assign pre_nxt = pre_q + 1'b1;
    assign os_tick = (tx_enable || rx_enable) && pre_nxt >= brr_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pre_q <= '0;
        end else if (ce) begin
            if (!(tx_enable || rx_enable) || os_tick) begin
                pre_q <= '0;
            end else begin
                pre_q <= pre_nxt;
            end
        end
    end

    // Transmitter ticks only while enabled, so counters freeze otherwise
    assign t_tick    = os_tick && tx_enable;
    assign bit_end   = t_tick && tx_cnt_q == 6'(osr - 5'd1);
    assign stop_end  = t_tick && tx_cnt_q == stop_ticks - 6'd1;
    assign frame_end = ce && tx_st_q == TX_STOP && stop_end;
    assign load_data = ce && tx_st_q == TX_IDLE && tx_enable
                       && !break_pending_q && !tx_buffer_empty_q;
    assign brk_clr   = ce && tx_st_q == TX_SHIFT && tx_brk_q
                       && bit_end && tx_bits_q == 4'd1;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_st_q   <= TX_OFF;
            tx_sh_q   <= '1;
            tx_bits_q <= '0;
            tx_cnt_q  <= '0;
            tx_dat_q  <= 1'b0;
            tx_brk_q  <= 1'b0;
        end else if (ce) begin
            unique case (tx_st_q)
                TX_OFF: begin
                    if (tx_enable) begin
                        tx_sh_q   <= '1;
                        tx_bits_q <= dbits + 4'd1;
                        tx_cnt_q  <= '0;
                        tx_dat_q  <= 1'b0;
                        tx_brk_q  <= 1'b0;
                        tx_st_q   <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    // Disable abandons the frame; re-enable opens with idle
                    if (!tx_enable) begin
                        tx_st_q <= TX_OFF;
                    end else if (bit_end) begin
                        tx_cnt_q <= '0;
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        if (tx_bits_q == 4'd1) begin
                            tx_st_q <= TX_STOP;
                        end else begin
                            tx_bits_q <= tx_bits_q - 4'd1;
                        end
                    end else if (t_tick) begin
                        tx_cnt_q <= tx_cnt_q + 6'd1;
                    end
                end
                TX_STOP: begin
                    if (!tx_enable) begin
                        tx_st_q <= TX_OFF;
                    end else if (stop_end) begin
                        tx_cnt_q <= '0;
                        tx_st_q  <= TX_IDLE;
                    end else if (t_tick) begin
                        tx_cnt_q <= tx_cnt_q + 6'd1;
                    end
                end
                TX_IDLE: begin
                    if (!tx_enable) begin
                        tx_st_q <= TX_OFF;
                    end else if (break_pending_q) begin
                        tx_sh_q   <= '0;
                        tx_bits_q <= dbits + 4'd2;
                        tx_dat_q  <= 1'b0;
                        tx_brk_q  <= 1'b1;
                        tx_st_q   <= TX_SHIFT;
                    end else if (!tx_buffer_empty_q) begin
                        tx_sh_q   <= {1'b1, thr_q, 1'b0};
                        tx_bits_q <= dbits + 4'd1;
                        tx_dat_q  <= 1'b1;
                        tx_brk_q  <= 1'b0;
                        tx_st_q   <= TX_SHIFT;
                    end
                end
            endcase
        end
    end

    // Holding register and empty flag; a new write outranks a move
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            thr_q             <= '0;
            tx_buffer_empty_q <= 1'b1;
        end else if (wr_thr) begin
            thr_q             <= wr_data_i[8:0];
            tx_buffer_empty_q <= 1'b0;
        end else if (load_data) begin
            tx_buffer_empty_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_done_q <= 1'b1;
        end else if (frame_end && tx_buffer_empty_q) begin
            tx_done_q <= 1'b1;
        end else if (wr_thr || (wr_req && wr_data_i[B_DONE])) begin
            tx_done_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            break_pending_q <= 1'b0;
        end else if (wr_req && wr_data_i[B_BRKRQ]) begin
            break_pending_q <= 1'b1;
        end else if (brk_clr) begin
            break_pending_q <= 1'b0;
        end
    end

    // Line and clock outputs; clock pulses only on data bits, second half
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_o                  <= 1'b1;
            sync_serial_clk_out_o <= 1'b0;
        end else if (ce) begin
            tx_o <= (tx_st_q == TX_SHIFT ? tx_sh_q[0] : 1'b1)
                    ^ cr2_q[B_TXINV];
            sync_serial_clk_out_o <= cr2_q[B_CLKEN] && tx_enable
                    && tx_st_q == TX_SHIFT && tx_dat_q
                    && tx_bits_q <= dbits
                    && tx_cnt_q >= 6'(osr >> 1);
        end
    end

    // Receiver start detection
    assign r_tick = os_tick && rx_enable;
    assign rxs    = rx_i ^ cr2_q[B_RXINV];
    assign idx    = rx_n_q + 4'd1;
    assign z1n    = rx_z1_q + 2'((idx == 4'd3 || idx == 4'd5 || idx == 4'd7) && !rxs);
    assign z2n    = rx_z2_q + 2'((idx >= 4'd8) && !rxs);
    assign rx_xfer = ce && rx_st_q == RX_DATA && r_tick
                     && rx_cnt_q == '0 && rx_k_q == dbits;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rx_st_q   <= RX_IDLE;
            rx_hist_q <= '0;
            rx_n_q    <= '0;
            rx_z1_q   <= '0;
            rx_z2_q   <= '0;
            rx_nz_q   <= 1'b0;
            rx_cnt_q  <= '0;
            rx_k_q    <= '0;
            rx_sh_q   <= '0;
        end else if (ce) begin
            if (!rx_enable) begin
                rx_st_q   <= RX_IDLE;
                rx_hist_q <= '0;
            end else if (r_tick) begin
                unique case (rx_st_q)
                    RX_IDLE: begin
                        rx_hist_q <= {rx_hist_q[1:0], rxs};
                        if (rx_hist_q == 3'b111 && !rxs) begin
                            rx_st_q <= RX_START;
                            rx_n_q  <= 4'd1;
                            rx_z1_q <= '0;
                            rx_z2_q <= '0;
                        end
                    end
                    RX_START: begin
                        rx_n_q  <= idx;
                        rx_z1_q <= z1n;
                        rx_z2_q <= z2n;
                        if (idx == 4'd7 && z1n < 2'd2) begin
                            rx_st_q   <= RX_IDLE;
                            rx_hist_q <= '0;
                        end else if (idx == SAMP_LAST) begin
                            if (z2n < 2'd2) begin
                                rx_st_q   <= RX_IDLE;
                                rx_hist_q <= '0;
                            end else begin
                                rx_nz_q  <= z1n != 2'd3 || z2n != 2'd3;
                                rx_st_q  <= RX_DATA;
                                rx_cnt_q <= osr + (osr >> 1) - 5'd11;
                                rx_k_q   <= '0;
                            end
                        end
                    end
                    RX_DATA: begin
                        if (rx_cnt_q != '0) begin
                            rx_cnt_q <= rx_cnt_q - 5'd1;
                        end else if (rx_k_q == dbits) begin
                            // Hand over at the stop centre so the next start edge is seen
                            rx_st_q   <= RX_IDLE;
                            rx_hist_q <= '0;
                        end else begin
                            rx_cnt_q <= osr - 5'd1;
                            rx_k_q   <= rx_k_q + 4'd1;
                            rx_sh_q  <= {rxs, rx_sh_q[8:1]};
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer and flags; hardware set wins over software clear
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rxbuf_q         <= '0;
            rx_data_ready_q <= 1'b0;
            noise_flag_q    <= 1'b0;
        end else begin
            if (rx_xfer) begin
                rxbuf_q         <= rx_sh_q >> (4'd9 - dbits);
                rx_data_ready_q <= 1'b1;
            end else if (rd_rxd) begin
                rx_data_ready_q <= 1'b0;
            end
            if (rx_xfer && rx_nz_q) begin
                noise_flag_q <= 1'b1;
            end else if (wr_req && wr_data_i[B_NOISE]) begin
                noise_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= '0;
            irq_o     <= 1'b0;
        end else if (ce) begin
            rd_data_o <= '0;
            if (rd_i) begin
                unique case (addr_i)
                    A_CR1:   rd_data_o <= cr1_q;
                    A_CR2:   rd_data_o <= cr2_q;
                    A_BRR:   rd_data_o <= 32'(brr_q);
                    A_STAT:  rd_data_o <= {23'h0, break_pending_q,
                                tx_buffer_empty_q, tx_done_q, rx_data_ready_q,
                                2'b00, noise_flag_q, 2'b00};
                    A_RXD:   rd_data_o <= {23'h0, rxbuf_q};
                    default: rd_data_o <= '0;
                endcase
            end
            irq_o <= (tx_buffer_empty_q && cr1_q[B_EMPTYIE])
                  || (tx_done_q && cr1_q[B_DONEIE])
                  || (rx_data_ready_q && cr1_q[B_RXIE]);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_wlen7;
        cr1_q[B_WLEN +: 2] == WL_7 |-> dbits == 4'd7 && tx_bits_q <= 4'd11;
    endproperty
    a_wlen7: assert property (p_wlen7) else $error("word length wrong");

    property p_stop_rst;
        $fell(sys_rst_i) |-> cr2_q[B_STOP +: 2] == STOP_1;
    endproperty
    a_stop_rst: assert property (p_stop_rst) else $error("stop reset");

    property p_freeze;
        ce && !tx_enable |=> tx_st_q == TX_OFF;
    endproperty
    a_freeze: assert property (p_freeze) else $error("tx not off");

    property p_empty_clr;
        wr_thr |=> !tx_buffer_empty_q ##1 1'b1;
    endproperty
    a_empty_clr: assert property (p_empty_clr) else $error("empty kept");

    property p_idle_load;
        load_data && !wr_thr |=> tx_buffer_empty_q && tx_st_q == TX_SHIFT
                                 && tx_dat_q;
    endproperty
    a_idle_load: assert property (p_idle_load) else $error("no load");

    property p_start_low;
        ce && tx_st_q == TX_SHIFT && tx_dat_q && tx_bits_q == dbits + 4'd1
        && !cr2_q[B_TXINV] |=> !tx_o;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start high");

    property p_brk_set;
        wr_req && wr_data_i[B_BRKRQ] |=> break_pending_q;
    endproperty
    a_brk_set: assert property (p_brk_set) else $error("brk not set");

    property p_brk_clr;
        brk_clr && !(wr_req && wr_data_i[B_BRKRQ])
        |=> !break_pending_q && tx_st_q == TX_STOP;
    endproperty
    a_brk_clr: assert property (p_brk_clr) else $error("brk kept");

    property p_done;
        frame_end && tx_buffer_empty_q |=> tx_done_q;
    endproperty
    a_done: assert property (p_done) else $error("done missing");

    property p_rx_ready;
        rx_xfer |=> rx_data_ready_q ##1 $stable(rxbuf_q) || rx_xfer;
    endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("rx ready");
endmodule : utx_core
`default_nettype wire

// ==== tb/utx_peer.sv ====
// Serial equipment model facing the character engine's tx and rx lines.
// Assumes divisor 1 and oversample 16, so one bit is 16 clock cycles.
`timescale 1ns/1ps
`default_nettype none
module utx_peer (
    input  wire logic ref_clk_i,
    input  wire logic tx_i,
    output logic      rx_o
);
    initial rx_o = 1'b1;
    // Set bits in gl force start-bit cycles high to fake line noise
    task automatic send(input logic [8:0] d, input int nb, input logic [15:0] gl);
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_i) rx_o <= gl[i];
        end
        for (int i = 0; i < nb * 16; i++) begin
            @(posedge ref_clk_i) rx_o <= d[i / 16];
        end
        repeat (16) @(posedge ref_clk_i) rx_o <= 1'b1;
    endtask : send
    // Low run from the first fall, then nb bits sampled at their centres
    task automatic capture(input int nb, output logic [8:0] d, output int low, output time tf);
        d = '0;
        low = 0;
        @(negedge tx_i);
        tf = $time;
        do begin
            @(posedge ref_clk_i);
            #1 low++;
        end while (tx_i === 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (i == 0 ? 8 : 16) @(posedge ref_clk_i);
            #1 d[i] = tx_i;
        end
    endtask : capture
endmodule : utx_peer
`default_nettype wire

// ==== tb/uart_tx_and_rx_start_detect_tb.sv ====
// Self-checking bench for the serial character engine.
// Assumes utx_peer on the serial lines; divisor 1 gives 16-cycle bits.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_and_rx_start_detect_tb
    import utx_pkg::*;
;
    localparam logic [7:0]  RA [5] = '{A_CR1, A_CR2, A_BRR, A_STAT, 8'h1C};
    localparam logic [31:0] RV [5] = '{32'h0, 32'h0, 32'h10, 32'hC0, 32'h0};
    localparam logic [1:0]  SC [4] = '{STOP_1, STOP_H, STOP_2, STOP_1H};
    localparam int          SL [4] = '{16, 8, 32, 24};
    localparam logic [1:0]  WL [3] = '{WL_7, 2'b00, WL_9};
    localparam logic [15:0] GL [6] = '{16'h0, 16'h10, 16'h100, 16'h110, 16'h14, 16'h180};
    localparam logic        RY [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    localparam logic        NZ [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdat      = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [31:0] rd_data, s;
    logic        rx, tx, sclk, irq;
    logic [8:0]  d;
    int          bad_count = 0;
    int          n_compared = 0;
    int          low, nb, cyc, c0;
    int          n_clk = 0;
    time         t_en, t1, t2;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    utx_core dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .rx_i(rx), .tx_o(tx),
        .sync_serial_clk_out_o(sclk), .irq_o(irq)
    );
    utx_peer peer (.ref_clk_i(ref_clk_i), .tx_i(tx), .rx_o(rx));
    always @(posedge sclk) n_clk++;
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        addr <= a;
        wdat <= v;
        wr   <= 1'b1;
        @(posedge ref_clk_i);
        wr   <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd   <= 1'b0;
        #1 v = rd_data;
    endtask : rreg
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        foreach (RA[i]) begin
            rreg(RA[i], s);
            `CHK(s, RV[i])
        end
        wreg(A_BRR, 32'h1);
        wreg(A_CR1, 32'h000D);
        t_en = $time;
        foreach (SC[k]) begin
            wreg(A_CR2, {18'h0, SC[k], 12'h800});
            wreg(A_THR, 32'h0A5);
            peer.capture(8, d, low, t1);
            cyc = int'((t1 - t_en) / 5);
            if (k == 0) `CHK(cyc inside {[160:168]}, 1'b1)
            `CHK(low, 16)
            c0 = n_clk;
            wreg(A_THR, 32'h0A5);
            rreg(A_STAT, s);
            `CHK(s[B_EMPTY], 1'b0)
            peer.capture(8, d, low, t2);
            `CHK(d, 9'h0A5)
            `CHK(n_clk - c0, 8)
            cyc = int'((t2 - t1) / 5) - 144 - SL[k];
            `CHK(cyc inside {[0:2]}, 1'b1)
        end
        repeat (80) @(posedge ref_clk_i);
        rreg(A_STAT, s);
        `CHK(s[7:6], 2'b11)
        wreg(A_CR2, 32'h0);
        foreach (WL[k]) begin
            nb = 7 + k;
            wreg(A_CR1, {20'h0, WL[k], 10'h08D});
            // The start bit leaves two cycles after the write, so listen first
            fork
                peer.capture(nb, d, low, t1);
                begin
                    wreg(A_THR, 32'h1A5);
                    rreg(A_STAT, s);
                    `CHK(s[7:6], 2'b10)
                    `CHK(irq, 1'b1)
                end
            join
            `CHK(d, 9'h1A5 & 9'((1 << nb) - 1))
            wreg(A_REQ, 32'h2);
            rreg(A_STAT, s);
            `CHK(s[B_BRK], 1'b1)
            peer.capture(0, d, low, t1);
            `CHK(low, (nb + 2) * 16)
            repeat (40) @(posedge ref_clk_i);
            rreg(A_STAT, s);
            `CHK(s[B_BRK], 1'b0)
        end
        wreg(A_THR, 32'h0A5);
        repeat (40) @(posedge ref_clk_i);
        wreg(A_CR1, 32'h0005);
        repeat (30) @(posedge ref_clk_i);
        #1 `CHK(tx, 1'b1)
        wreg(A_CR2, 32'h20000);
        repeat (3) @(posedge ref_clk_i);
        #1 `CHK(tx, 1'b0)
        wreg(A_CR2, 32'h0);
        wreg(A_CR1, 32'h800D);
        wreg(A_THR, 32'h0A5);
        peer.capture(0, d, low, t1);
        `CHK(low, 8)
        repeat (80) @(posedge ref_clk_i);
        rreg(A_STAT, s);
        `CHK(s[B_DONE], 1'b1)
        wreg(A_CR1, 32'h0005);
        foreach (GL[k]) begin
            peer.send(9'h03C + 9'(k), RY[k] ? 8 : 0, GL[k]);
            repeat (4) @(posedge ref_clk_i);
            rreg(A_STAT, s);
            `CHK(s[B_RXRDY], RY[k])
            `CHK(s[B_NOISE], NZ[k])
            rreg(A_RXD, s);
            if (RY[k]) `CHK(s[8:0], 9'h03C + 9'(k))
            wreg(A_REQ, 32'h4);
        end
        // Inverted idle line reads as a steady low: one clean all-zero character
        wreg(A_CR2, 32'h10000);
        repeat (200) @(posedge ref_clk_i);
        wreg(A_CR2, 32'h0);
        rreg(A_STAT, s);
        `CHK(s[B_RXRDY], 1'b1)
        `CHK(s[B_NOISE], 1'b0)
        rreg(A_RXD, s);
        `CHK(s[8:0], 9'h000)
        report_and_stop();
    end
endmodule : uart_tx_and_rx_start_detect_tb
`default_nettype wire
